// ### logic/fpec_defs.svh
// address map, control bit positions and masks for the flash sequencer
`ifndef FPEC_DEFS_SVH
`define FPEC_DEFS_SVH
`define FPEC_CTRL_ADDR   16'hFE08
`define FPEC_LOCK_ADDR   16'hFFF0
`define FPEC_USER_LO     16'h7800
`define FPEC_USER_HI     16'h7FEF
`define FPEC_VEC_LO      16'hFFF0
`define FPEC_VEC_HI      16'hFFFF
`define FPEC_VEC_BASE    7'h7F
`define FPEC_LOCK_IDX    11'h7F0
`define FPEC_BIT_PGM     0
`define FPEC_BIT_ERASE   1
`define FPEC_BIT_MARGIN  2
`define FPEC_BIT_HIGH_VOLTAGE_ENABLE    3
`define FPEC_BIT_ERASE_SIZE_LOWER    4
`define FPEC_BIT_ERASE_SIZE_UPPER    5
`define FPEC_BIT_PUMP_DIVIDE_BITS    6
`define FPEC_CTRL_RST    1'b0
`define FPEC_BYTE_ERASED 8'h00
`define FPEC_MARGIN_XTRA 4'h8
`define FPEC_CNT_ONE     4'h1
`define FPEC_CNT_ZERO    4'h0
`define FPEC_MASK_FULL   11'h000
`define FPEC_MASK_HALF   11'h400
`define FPEC_MASK_8ROW   11'h7C0
`define FPEC_MASK_ROW    11'h7F8
`define FPEC_LOCK_B0     12'h000
`define FPEC_LOCK_B1     12'h080
`define FPEC_LOCK_B2     12'h100
`define FPEC_LOCK_B3     12'h200
`define FPEC_LOCK_NONE   12'h800
`endif

// ### logic/fpec_pkg.sv
// types shared by the flash sequencer
package fpec_pkg;
    typedef enum logic {FPEC_RD_IDLE, FPEC_RD_STRETCH} fpec_rd_state_t;
    typedef enum logic [1:0] {FPEC_ERA_FULL, FPEC_ERA_HALF, FPEC_ERA_8ROW,
                              FPEC_ERA_ROW} fpec_era_size_t;
endpackage

// ### logic/fpec_pump_div.sv
// charge pump clock enable divider
`timescale 1ns/1ps
`include "fpec_defs.svh"
module fpec_pump_div (
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    // control
    input  wire logic i_run,
    input  wire logic i_div2,
    // pump clock enable
    output logic      o_pump_tick
);
    logic phase_r;
    logic phase_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb begin
        phase_nxt = i_run & ~phase_r;
        tick_nxt  = i_run & (~i_div2 | ~phase_r); // R11 R24
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_r <= `FPEC_CTRL_RST;
            tick_r  <= `FPEC_CTRL_RST;
        end else begin
            phase_r <= phase_nxt;
            tick_r  <= tick_nxt;
        end
    end

    assign o_pump_tick = tick_r;

    a_div_two_gap: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R11
        (i_run && i_div2 && tick_r) |=> !tick_r)
        else $error("pump tick repeated in divide-by-two");

    a_tick_stops: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R24
        !i_run |=> !tick_r)
        else $error("pump tick without run request");
endmodule // fpec_pump_div

// ### logic/fpec_top.sv
// flash program/erase sequencer with its byte array and control register
// What this block does
// [R1] erased bit reads 0, programmed reads 1
// [R2] 2032 user bytes, 15 vectors, lock byte
// [R3] decode user, control, lock and vector addresses
// [R4] byte programming, erase at least one row
// [R5] block size bits pick erase extent
// [R6] erase set-up write latches block address
// [R7] high voltage only after select and sequence
// [R8] high voltage bit drives pump and array
// [R9] margin refused while high voltage on
// [R10] program and erase never both set
// [R11] pump clock is bus divided by one/two
// [R12] software keeps bus clock at least 2 MHz
// [R13] software erase set-up order before high voltage
// [R14] software erase timing and release order
// [R15] program select latches next array write
// [R16] software program step order
// [R17] software margin verify and retry order
// [R18] margin array read stretched eight cycles
// [R19] software erases row after eight programs
// [R20] steps ordered, unrelated accesses tolerated
// [R21] lock byte read latched, protected range drops select
// [R22] lock bit guards start..7FEF plus vectors
// [R23] control bits reset to zero, unused zero
// [R24] clearing high voltage stops pump at once
`timescale 1ns/1ps
`include "fpec_defs.svh"
module fpec_top #(
    parameter int DEPTH = 2048
) (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // cpu access
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [7:0]       o_rdata,
    output logic             o_rd_valid,
    output logic             o_busy,
    // analog side
    output logic             o_hv_on,
    output logic             o_pump_tick,
    output logic             o_margin_mode
);
    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic in_array(input logic [15:0] a);
        return (a >= `FPEC_USER_LO && a <= `FPEC_USER_HI) ||
               (a >= `FPEC_VEC_LO && a <= `FPEC_VEC_HI); // R2 R3
    endfunction

    // vectors fold into the unused top slot of the user window
    function automatic logic [10:0] to_idx(input logic [15:0] a);
        return (a >= `FPEC_VEC_LO) ? {`FPEC_VEC_BASE, a[3:0]} : a[10:0]; // R3
    endfunction

    function automatic logic [10:0] era_mask(input logic [1:0] sz);
        case (fpec_pkg::fpec_era_size_t'(sz)) // R5
            fpec_pkg::FPEC_ERA_FULL: return `FPEC_MASK_FULL;
            fpec_pkg::FPEC_ERA_HALF: return `FPEC_MASK_HALF;
            fpec_pkg::FPEC_ERA_8ROW: return `FPEC_MASK_8ROW;
            default:                 return `FPEC_MASK_ROW; // R4
        endcase
    endfunction

    // lowest programmed lock bit sets where the guarded range begins
    function automatic logic [11:0] lock_start(input logic [7:0] b);
        if (b[0])      return `FPEC_LOCK_B0; // R22
        else if (b[1]) return `FPEC_LOCK_B1;
        else if (b[2]) return `FPEC_LOCK_B2;
        else if (b[3]) return `FPEC_LOCK_B3;
        else           return `FPEC_LOCK_NONE;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0]  mem_r [DEPTH];
    logic [7:0]  mem_nxt [DEPTH];
    logic        pgm_r, pgm_nxt, era_r, era_nxt, mar_r, mar_nxt;
    logic        hv_r, hv_nxt, div_r, div_nxt;
    logic [1:0]  blk_r, blk_nxt;
    logic        lkrd_r, lkrd_nxt, lat_r, lat_nxt;
    logic [7:0]  lock_r, lock_nxt, ldat_r, ldat_nxt;
    logic [10:0] lidx_r, lidx_nxt;
    fpec_pkg::fpec_rd_state_t rst_r, rst_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic [7:0]  rdat_r, rdat_nxt;
    logic        rval_r, rval_nxt;
    logic        ctrl_wr, arr_wr, arr_rd, hv_rise, guarded;
    logic [10:0] widx, blk_end;
    logic [7:0]  ctrl_val;

    // ************************************************************
    // control register and sequence tracking
    // ************************************************************
    always_comb begin
        ctrl_wr  = i_wr && (i_addr == `FPEC_CTRL_ADDR);
        arr_wr   = i_wr && in_array(i_addr);
        arr_rd   = i_rd && in_array(i_addr) && (rst_r == fpec_pkg::FPEC_RD_IDLE);
        widx     = to_idx(i_addr);
        ctrl_val = {1'b0, div_r, blk_r[1], blk_r[0], hv_r, mar_r, era_r, pgm_r}; // R23
        blk_end  = widx | ~era_mask(blk_r);
        guarded  = pgm_r ? ({1'b0, widx} >= lock_start(lock_r))
                         : ({1'b0, blk_end} >= lock_start(lock_r)); // R21 R22
        pgm_nxt  = pgm_r;
        era_nxt  = era_r;
        mar_nxt  = mar_r;
        hv_nxt   = hv_r;
        div_nxt  = div_r;
        blk_nxt  = blk_r;
        lkrd_nxt = lkrd_r;
        lat_nxt  = lat_r;
        lock_nxt = lock_r;
        ldat_nxt = ldat_r;
        lidx_nxt = lidx_r;
        if (ctrl_wr) begin
            div_nxt = i_wdata[`FPEC_BIT_PUMP_DIVIDE_BITS];
            blk_nxt = {i_wdata[`FPEC_BIT_ERASE_SIZE_UPPER], i_wdata[`FPEC_BIT_ERASE_SIZE_LOWER]};
            // a write asking for both selects keeps the old selects; the other bits still load
            if (!(i_wdata[`FPEC_BIT_PGM] && i_wdata[`FPEC_BIT_ERASE])) begin // R10
                pgm_nxt = i_wdata[`FPEC_BIT_PGM];
                era_nxt = i_wdata[`FPEC_BIT_ERASE];
            end
            hv_nxt  = i_wdata[`FPEC_BIT_HIGH_VOLTAGE_ENABLE] && (pgm_nxt || era_nxt) &&
                      (hv_r || (lkrd_r && lat_r)); // R7 R24
            mar_nxt = i_wdata[`FPEC_BIT_MARGIN] && !hv_nxt; // R9
            if (pgm_nxt != pgm_r || era_nxt != era_r) begin
                lkrd_nxt = 1'b0;
                lat_nxt  = 1'b0;
            end
        end else if (arr_rd && widx == `FPEC_LOCK_IDX && (pgm_r || era_r)) begin
            lock_nxt = mem_r[`FPEC_LOCK_IDX]; // R21
            lkrd_nxt = 1'b1;
        end else if (arr_wr && lkrd_r && !lat_r && !hv_r && (pgm_r || era_r)) begin // R20
            if (guarded) begin
                pgm_nxt = 1'b0; // R21
                era_nxt = 1'b0;
                lkrd_nxt = 1'b0;
            end else begin
                lidx_nxt = widx; // R6 R15
                ldat_nxt = i_wdata;
                lat_nxt  = 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pgm_r  <= `FPEC_CTRL_RST; // R23
            era_r  <= `FPEC_CTRL_RST;
            mar_r  <= `FPEC_CTRL_RST;
            hv_r   <= `FPEC_CTRL_RST;
            div_r  <= `FPEC_CTRL_RST;
            blk_r  <= {2{`FPEC_CTRL_RST}};
            lkrd_r <= `FPEC_CTRL_RST;
            lat_r  <= `FPEC_CTRL_RST;
            lock_r <= `FPEC_BYTE_ERASED;
            ldat_r <= `FPEC_BYTE_ERASED;
            lidx_r <= '0;
        end else begin
            pgm_r  <= pgm_nxt;
            era_r  <= era_nxt;
            mar_r  <= mar_nxt;
            hv_r   <= hv_nxt;
            div_r  <= div_nxt;
            blk_r  <= blk_nxt;
            lkrd_r <= lkrd_nxt;
            lat_r  <= lat_nxt;
            lock_r <= lock_nxt;
            ldat_r <= ldat_nxt;
            lidx_r <= lidx_nxt;
        end
    end

    // ************************************************************
    // array cells: one high voltage pulse programs or erases
    // ************************************************************
    always_comb begin
        hv_rise = hv_nxt && !hv_r;
        for (int i = 0; i < DEPTH; i++) begin
            mem_nxt[i] = mem_r[i];
            if (hv_rise && pgm_nxt && lidx_r == 11'(i))
                mem_nxt[i] = mem_r[i] | ldat_r; // R1 R4 R8
            else if (hv_rise && era_nxt &&
                     ((11'(i) & era_mask(blk_r)) == (lidx_r & era_mask(blk_r))))
                mem_nxt[i] = `FPEC_BYTE_ERASED; // R1 R5 R6 R8
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < DEPTH; i++)
                mem_r[i] <= `FPEC_BYTE_ERASED;
        end else begin
            for (int i = 0; i < DEPTH; i++)
                mem_r[i] <= mem_nxt[i];
        end
    end

    // ************************************************************
    // read port; margin reads wait eight extra cycles
    // ************************************************************
    always_comb begin
        rst_nxt  = rst_r;
        cnt_nxt  = cnt_r;
        rdat_nxt = rdat_r;
        rval_nxt = 1'b0;
        case (rst_r)
            fpec_pkg::FPEC_RD_IDLE: begin
                if (i_rd) begin
                    if (i_addr == `FPEC_CTRL_ADDR)
                        rdat_nxt = ctrl_val; // R3
                    else if (in_array(i_addr))
                        rdat_nxt = mem_r[to_idx(i_addr)];
                    else
                        rdat_nxt = `FPEC_BYTE_ERASED;
                    if (arr_rd && mar_r) begin
                        rst_nxt = fpec_pkg::FPEC_RD_STRETCH; // R18
                        cnt_nxt = `FPEC_MARGIN_XTRA;
                    end else begin
                        rval_nxt = 1'b1;
                    end
                end
            end
            fpec_pkg::FPEC_RD_STRETCH: begin
                cnt_nxt = cnt_r - `FPEC_CNT_ONE;
                if (cnt_r == `FPEC_CNT_ONE) begin
                    rval_nxt = 1'b1; // R18
                    rst_nxt  = fpec_pkg::FPEC_RD_IDLE;
                end
            end
            default: rst_nxt = fpec_pkg::FPEC_RD_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_r  <= fpec_pkg::FPEC_RD_IDLE;
            cnt_r  <= `FPEC_CNT_ZERO;
            rdat_r <= `FPEC_BYTE_ERASED;
            rval_r <= 1'b0;
        end else begin
            rst_r  <= rst_nxt;
            cnt_r  <= cnt_nxt;
            rdat_r <= rdat_nxt;
            rval_r <= rval_nxt;
        end
    end

    fpec_pump_div u_pump (
        .i_ref_clk   (i_ref_clk),
        .i_rst_n     (i_rst_n),
        .i_run       (hv_nxt), // R24
        .i_div2      (div_r),
        .o_pump_tick (o_pump_tick)
    );

    assign o_rdata       = rdat_r;
    assign o_rd_valid    = rval_r;
    assign o_busy        = (rst_r == fpec_pkg::FPEC_RD_STRETCH);
    assign o_hv_on       = hv_r; // R8
    assign o_margin_mode = mar_r;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    a_sel_exclusive: assert property (!(pgm_r && era_r)) // R10
        else $error("program and erase both selected");
    a_hv_needs_sel: assert property ($rose(hv_r) |-> (pgm_r || era_r) && $past(lat_r)) // R7
        else $error("high voltage without prepared sequence");
    a_margin_refused: assert property (hv_r |-> !mar_r) // R9
        else $error("margin set with high voltage on");
    a_margin_stretch: assert property ((arr_rd && mar_r) |=> !rval_r [*8] ##1 rval_r) // R18
        else $error("margin read not stretched by eight");
    a_plain_read: assert property ((i_rd && !o_busy && !(arr_rd && mar_r)) |=> rval_r) // R20
        else $error("plain read did not answer next cycle");
    a_pump_stops: assert property ($fell(hv_r) |-> !o_pump_tick [*2]) // R24
        else $error("pump ran after high voltage cleared");
    a_pump_runs: assert property ($rose(hv_r) |-> o_pump_tick) // R8
        else $error("pump idle with high voltage on");
    a_guard_drop: assert property ((arr_wr && !ctrl_wr && lkrd_r && !lat_r && !hv_r &&
        (pgm_r || era_r) && guarded) |=> !pgm_r && !era_r) // R21
        else $error("protected target kept its select");
    a_prog_sets: assert property (($rose(hv_r) && pgm_r) |-> // R1
        ((mem_r[lidx_r] & ldat_r) == ldat_r))
        else $error("programmed bits not read as one");
    c_program: cover property ($rose(hv_r) && pgm_r);
    c_erase: cover property ($rose(hv_r) && era_r);
    c_margin_read: cover property (arr_rd && mar_r);
    c_guard: cover property (arr_wr && lkrd_r && guarded && (pgm_r || era_r));
endmodule // fpec_top

// ### tb/fpec_top_bench.sv
// self-checking bench for the flash program/erase sequencer
`timescale 1ns/1ps
`include "fpec_defs.svh"
module fpec_top_bench;
    // ************************************************************
    // signals
    // ************************************************************
    logic        i_ref_clk;
    logic        i_rst_n;
    logic [15:0] i_addr;
    logic [7:0]  i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [7:0]  o_rdata;
    logic        o_rd_valid;
    logic        o_busy;
    logic        o_hv_on;
    logic        o_pump_tick;
    logic        o_margin_mode;
    int          n_errors;
    int          n_checks;
    logic        busy_first;

    fpec_top DUT (
        .i_ref_clk     (i_ref_clk),
        .i_rst_n       (i_rst_n),
        .i_addr        (i_addr),
        .i_wdata       (i_wdata),
        .i_wr          (i_wr),
        .i_rd          (i_rd),
        .o_rdata       (o_rdata),
        .o_rd_valid    (o_rd_valid),
        .o_busy        (o_busy),
        .o_hv_on       (o_hv_on),
        .o_pump_tick   (o_pump_tick),
        .o_margin_mode (o_margin_mode)
    );

    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    // ************************************************************
    // access tasks
    // ************************************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        i_addr  = a;
        i_wdata = d;
        i_wr    = 1'b1;
        @(negedge i_ref_clk);
        i_wr    = 1'b0;
    endtask

    // read and check data plus the cycles until the answer
    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input int lat);
        int n;
        @(negedge i_ref_clk);
        i_addr = a;
        i_rd   = 1'b1;
        n      = 0;
        do begin
            @(negedge i_ref_clk);
            i_rd = 1'b0;
            n++;
            if (n == 1) busy_first = o_busy;
        end while (o_rd_valid !== 1'b1 && n < 40);
        chk("read data", exp, o_rdata);
        chk("read latency", 8'(lat), 8'(n));
    endtask

    // full program pass with margin verify; fd is the pump divide bit
    task automatic prog_byte(input logic [15:0] a, input logic [7:0] d, input logic fd);
        logic [7:0] f;
        int ticks;
        f = {1'b0, fd, 6'h00};
        wr(`FPEC_CTRL_ADDR, f | 8'h01);
        rdchk(`FPEC_LOCK_ADDR, 8'h00, 1);
        wr(a, d);
        wr(`FPEC_CTRL_ADDR, f | 8'h09);
        chk("hv on", 8'h01, {7'h0, o_hv_on});
        ticks = 0;
        repeat (8) begin
            @(negedge i_ref_clk);
            ticks += int'(o_pump_tick === 1'b1);
        end
        chk("pump ticks", fd ? 8'h04 : 8'h08, 8'(ticks));
        wr(`FPEC_CTRL_ADDR, f | 8'h0D);
        rdchk(`FPEC_CTRL_ADDR, f | 8'h09, 1);
        chk("margin out", 8'h00, {7'h0, o_margin_mode});
        wr(`FPEC_CTRL_ADDR, f | 8'h01);
        chk("hv off", 8'h00, {7'h0, o_hv_on});
        chk("pump stopped", 8'h00, {7'h0, o_pump_tick});
        wr(`FPEC_CTRL_ADDR, f | 8'h05);
        chk("margin on", 8'h01, {7'h0, o_margin_mode});
        wr(`FPEC_CTRL_ADDR, f | 8'h04);
        rdchk(a, d, 9);
        chk("busy in stretch", 8'h01, {7'h0, busy_first});
        wr(`FPEC_CTRL_ADDR, 8'h00);
    endtask

    task automatic erase(input logic [15:0] a, input logic [1:0] blk, input logic [7:0] lk);
        wr(`FPEC_CTRL_ADDR, {2'b00, blk, 4'h2});
        rdchk(`FPEC_LOCK_ADDR, lk, 1);
        rdchk(16'h1234, 8'h00, 1);
        wr(a, 8'h5A);
        wr(`FPEC_CTRL_ADDR, {2'b00, blk, 4'hA});
        chk("erase hv", 8'h01, {7'h0, o_hv_on});
        wr(`FPEC_CTRL_ADDR, {2'b00, blk, 4'h2});
        wr(`FPEC_CTRL_ADDR, 8'h00);
    endtask

    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ************************************************************
    // watchdog
    // ************************************************************
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        n_errors++;
        results();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        n_errors = 0;
        n_checks = 0;
        i_rst_n  = 1'b0;
        i_addr   = 16'h0000;
        i_wdata  = 8'h00;
        i_wr     = 1'b0;
        i_rd     = 1'b0;
        busy_first = 1'b0;
        repeat (16) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        rdchk(`FPEC_CTRL_ADDR, 8'h00, 1);
        rdchk(16'h7800, 8'h00, 1);
        rdchk(16'hFFFE, 8'h00, 1);
        rdchk(16'h1234, 8'h00, 1);
        // interlock and refused high voltage without select
        wr(`FPEC_CTRL_ADDR, 8'h03);
        rdchk(`FPEC_CTRL_ADDR, 8'h00, 1);
        wr(`FPEC_CTRL_ADDR, 8'hF8);
        rdchk(`FPEC_CTRL_ADDR, 8'h70, 1);
        chk("hv refused", 8'h00, {7'h0, o_hv_on});
        wr(`FPEC_CTRL_ADDR, 8'h00);
        // two programs, both pump divides
        prog_byte(16'h7810, 8'hA5, 1'b0);
        prog_byte(16'h7818, 8'h3C, 1'b1);
        // single row erase leaves the neighbour row
        erase(16'h7813, 2'b11, 8'h00);
        rdchk(16'h7810, 8'h00, 1);
        rdchk(16'h7818, 8'h3C, 1);
        // lock from 0x7A00 upward plus vectors
        prog_byte(`FPEC_LOCK_ADDR, 8'h08, 1'b0);
        wr(`FPEC_CTRL_ADDR, 8'h01);
        rdchk(`FPEC_LOCK_ADDR, 8'h08, 1);
        wr(16'h7A00, 8'hFF);
        rdchk(`FPEC_CTRL_ADDR, 8'h00, 1);
        wr(`FPEC_CTRL_ADDR, 8'h09);
        chk("hv locked", 8'h00, {7'h0, o_hv_on});
        wr(`FPEC_CTRL_ADDR, 8'h00);
        rdchk(16'h7A00, 8'h00, 1);
        // full erase covers the locked range
        wr(`FPEC_CTRL_ADDR, 8'h02);
        rdchk(`FPEC_LOCK_ADDR, 8'h08, 1);
        wr(16'h7800, 8'h00);
        rdchk(`FPEC_CTRL_ADDR, 8'h00, 1);
        // lower half erase also reaches the locked range
        wr(`FPEC_CTRL_ADDR, 8'h12);
        rdchk(`FPEC_LOCK_ADDR, 8'h08, 1);
        wr(16'h7800, 8'h00);
        rdchk(`FPEC_CTRL_ADDR, 8'h10, 1);
        // eight row erase below the lock still works
        wr(`FPEC_CTRL_ADDR, 8'h00);
        erase(16'h7830, 2'b10, 8'h08);
        rdchk(16'h7818, 8'h00, 1);
        rdchk(`FPEC_LOCK_ADDR, 8'h08, 1);
        results();
    end
endmodule // fpec_top_bench
